// file: src/tsg_pkg.sv
package tsg_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 12;
  localparam int DLY_W = 4;
  localparam int COLOR_W = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] SIZE_OFF = 8'h04;
  localparam logic [7:0] HTIM_OFF = 8'h08;
  localparam logic [7:0] VTIM_OFF = 8'h0C;
  localparam logic [7:0] POL_OFF = 8'h10;
  localparam logic [7:0] CLKDIV_OFF = 8'h14;
  localparam logic [7:0] PIX_OFF = 8'h18;
  localparam logic [7:0] STAT_OFF = 8'h1C;
  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int HPOL_BIT = 0;
  localparam int VPOL_BIT = 1;
  localparam int CKINV_BIT = 0;
  localparam int DLY_LSB = 4;
  localparam int HI_LSB = 16;
  localparam int SW_W = 8;
  localparam int SBP_LSB = 8;
  localparam int SFP_LSB = 16;
  // reset values
  localparam logic [CNT_W-1:0] WIDTH_RST = 12'h280;
  localparam logic [CNT_W-1:0] HEIGHT_RST = 12'h1E0;
  localparam logic [SW_W-1:0] HSW_RST = 8'h60;
  localparam logic [SW_W-1:0] HBP_RST = 8'h30;
  localparam logic [SW_W-1:0] HFP_RST = 8'h10;
  localparam logic [SW_W-1:0] VSW_RST = 8'h02;
  localparam logic [SW_W-1:0] VBP_RST = 8'h21;
  localparam logic [SW_W-1:0] VFP_RST = 8'h0A;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TSG_SYNC = 2'b00,
    TSG_BACK = 2'b01,
    TSG_ACTIVE = 2'b11,
    TSG_FRONT = 2'b10
  } tsg_phase_e;
endpackage

// file: src/tsg_axis.sv
`timescale 1ns/1ps
// one-axis phase counter: sync, back porch, active, front porch
module tsg_axis (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic step,
  input wire logic [tsg_pkg::SW_W-1:0] sync_len,
  input wire logic [tsg_pkg::SW_W-1:0] back_len,
  input wire logic [tsg_pkg::CNT_W-1:0] act_len,
  input wire logic [tsg_pkg::SW_W-1:0] front_len,
  output tsg_pkg::tsg_phase_e phase,
  output logic wrap
);
  logic [tsg_pkg::CNT_W-1:0] cnt_r;
  logic [tsg_pkg::CNT_W-1:0] len;
  tsg_pkg::tsg_phase_e phase_r;
  logic last;

  always_comb begin
    case (phase_r)
      tsg_pkg::TSG_SYNC: len = {4'h0, sync_len};
      tsg_pkg::TSG_BACK: len = {4'h0, back_len};
      tsg_pkg::TSG_ACTIVE: len = act_len;
      tsg_pkg::TSG_FRONT: len = {4'h0, front_len};
      default: len = act_len;
    endcase
  end

  // zero lengths count as one so no phase vanishes
  assign last = (cnt_r + 12'h001 >= len);
  assign wrap = step && last && (phase_r == tsg_pkg::TSG_FRONT);
  assign phase = phase_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_r <= '0;
      phase_r <= tsg_pkg::TSG_SYNC;
    end else if (step) begin
      if (last) begin
        cnt_r <= '0;
        case (phase_r)
          tsg_pkg::TSG_SYNC: phase_r <= tsg_pkg::TSG_BACK;
          tsg_pkg::TSG_BACK: phase_r <= tsg_pkg::TSG_ACTIVE;
          tsg_pkg::TSG_ACTIVE: phase_r <= tsg_pkg::TSG_FRONT;
          tsg_pkg::TSG_FRONT: phase_r <= tsg_pkg::TSG_SYNC;
          default: phase_r <= tsg_pkg::TSG_SYNC;
        endcase
      end else begin
        cnt_r <= cnt_r + 12'h001;
      end
    end
  end
endmodule // tsg_axis

// file: src/tsg_timing_gen.sv
`timescale 1ns/1ps
module tsg_timing_gen (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tsg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [tsg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tsg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [tsg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pixel_clk_out,
  output logic line_sync,
  output logic frame_sync,
  output logic pixel_valid_out,
  output logic [23:0] line_data
);
  logic enable_r;
  logic [tsg_pkg::CNT_W-1:0] width_r, height_r;
  logic [tsg_pkg::SW_W-1:0] hsw_r, hbp_r, hfp_r;
  logic [tsg_pkg::SW_W-1:0] vsw_r, vbp_r, vfp_r;
  logic hpol_r, vpol_r, ckinv_r;
  logic [tsg_pkg::DLY_W-1:0] dly_r;
  logic [23:0] pix_r;
  logic aw_have_r, w_have_r;
  logic [tsg_pkg::ADDR_W-1:0] awaddr_r;
  logic [tsg_pkg::DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_hit;
  logic [tsg_pkg::DATA_W-1:0] rd_val;
  logic rd_hit;
  localparam int ADDR_LSB = 2;
  localparam int TAPS = 1 << tsg_pkg::DLY_W;
  localparam logic [3:0] STRB_ALL = 4'hF;
  logic [tsg_pkg::ADDR_W-1:0] wr_word, rd_word;
  logic div_r;
  logic [TAPS-1:0] dline_r;
  logic step;
  logic act_area;
  logic line_wrap, frame_wrap;
  tsg_pkg::tsg_phase_e hphase, vphase;
  logic [tsg_pkg::CNT_W-1:0] line_cnt_r;
  logic hs_r, vs_r, de_r;

  // write channel capture, address and data in either order
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  // word-aligned register select
  assign wr_word = {awaddr_r[tsg_pkg::ADDR_W-1:ADDR_LSB], {ADDR_LSB{1'b0}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (wr_word)
      tsg_pkg::CTRL_OFF, tsg_pkg::SIZE_OFF, tsg_pkg::HTIM_OFF,
      tsg_pkg::VTIM_OFF, tsg_pkg::POL_OFF, tsg_pkg::CLKDIV_OFF,
      tsg_pkg::PIX_OFF, tsg_pkg::STAT_OFF: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tsg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? tsg_pkg::RESP_OKAY : tsg_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers, every register write needs all four strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_r <= 1'b0;
      width_r <= tsg_pkg::WIDTH_RST;
      height_r <= tsg_pkg::HEIGHT_RST;
      hsw_r <= tsg_pkg::HSW_RST;
      hbp_r <= tsg_pkg::HBP_RST;
      hfp_r <= tsg_pkg::HFP_RST;
      vsw_r <= tsg_pkg::VSW_RST;
      vbp_r <= tsg_pkg::VBP_RST;
      vfp_r <= tsg_pkg::VFP_RST;
      hpol_r <= 1'b0;
      vpol_r <= 1'b0;
      ckinv_r <= 1'b0;
      dly_r <= '0;
      pix_r <= '0;
    end else if (wr_go && wstrb_r == STRB_ALL) begin
      case (wr_word)
        tsg_pkg::CTRL_OFF: enable_r <= wdata_r[tsg_pkg::ENABLE_BIT];
        tsg_pkg::SIZE_OFF: begin
          width_r <= wdata_r[tsg_pkg::CNT_W-1:0];
          height_r <= wdata_r[tsg_pkg::HI_LSB +: tsg_pkg::CNT_W];
        end
        tsg_pkg::HTIM_OFF: begin
          hsw_r <= wdata_r[tsg_pkg::SW_W-1:0];
          hbp_r <= wdata_r[tsg_pkg::SBP_LSB +: tsg_pkg::SW_W];
          hfp_r <= wdata_r[tsg_pkg::SFP_LSB +: tsg_pkg::SW_W];
        end
        tsg_pkg::VTIM_OFF: begin
          vsw_r <= wdata_r[tsg_pkg::SW_W-1:0];
          vbp_r <= wdata_r[tsg_pkg::SBP_LSB +: tsg_pkg::SW_W];
          vfp_r <= wdata_r[tsg_pkg::SFP_LSB +: tsg_pkg::SW_W];
        end
        tsg_pkg::POL_OFF: begin
          hpol_r <= wdata_r[tsg_pkg::HPOL_BIT];
          vpol_r <= wdata_r[tsg_pkg::VPOL_BIT];
        end
        tsg_pkg::CLKDIV_OFF: begin
          ckinv_r <= wdata_r[tsg_pkg::CKINV_BIT];
          dly_r <= wdata_r[tsg_pkg::DLY_LSB +: tsg_pkg::DLY_W];
        end
        tsg_pkg::PIX_OFF: pix_r <= wdata_r[23:0];
        default: enable_r <= enable_r;
      endcase
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_word = {s_axi_araddr[tsg_pkg::ADDR_W-1:ADDR_LSB],
    {ADDR_LSB{1'b0}}};

  always_comb begin
    rd_hit = 1'b1;
    case (rd_word)
      tsg_pkg::CTRL_OFF: rd_val = {31'h0, enable_r};
      tsg_pkg::SIZE_OFF: rd_val = {4'h0, height_r, 4'h0, width_r};
      tsg_pkg::HTIM_OFF: rd_val = {8'h00, hfp_r, hbp_r, hsw_r};
      tsg_pkg::VTIM_OFF: rd_val = {8'h00, vfp_r, vbp_r, vsw_r};
      tsg_pkg::POL_OFF: rd_val = {30'h0, vpol_r, hpol_r};
      tsg_pkg::CLKDIV_OFF: rd_val = {24'h0, 3'h0, 1'b0, 3'h0, ckinv_r}
        | {24'h0, dly_r, 4'h0};
      tsg_pkg::PIX_OFF: rd_val = {8'h00, pix_r};
      tsg_pkg::STAT_OFF: rd_val = {4'h0, line_cnt_r, 12'h000,
        hphase, vphase};
      default: begin
        rd_val = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= tsg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? tsg_pkg::RESP_OKAY : tsg_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // pixel clock: aclk divided by two, one pixel per two aclk cycles
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      div_r <= 1'b0;
    end else begin
      div_r <= !div_r;
    end
  end

  // step two aclk cycles before the outgoing pixel clock rises, with tap 0 and no inversion
  assign step = enable_r && div_r;

  // delay line for the pixel clock, tap chosen by dly_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dline_r <= '0;
      pixel_clk_out <= 1'b0;
    end else begin
      dline_r <= {dline_r[TAPS-2:0], div_r};
      pixel_clk_out <= (enable_r ? dline_r[dly_r] : 1'b0) ^ ckinv_r;
    end
  end

  tsg_axis u_horiz (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable_r),
    .step(step),
    .sync_len(hsw_r),
    .back_len(hbp_r),
    .act_len(width_r),
    .front_len(hfp_r),
    .phase(hphase),
    .wrap(line_wrap)
  );

  tsg_axis u_vert (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(enable_r),
    .step(line_wrap),
    .sync_len(vsw_r),
    .back_len(vbp_r),
    .act_len(height_r),
    .front_len(vfp_r),
    .phase(vphase),
    .wrap(frame_wrap)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      line_cnt_r <= '0;
    end else if (frame_wrap) begin
      line_cnt_r <= '0;
    end else if (line_wrap) begin
      line_cnt_r <= line_cnt_r + 12'h001;
    end
  end

  // data enable only with both axes active
  assign act_area = (hphase == tsg_pkg::TSG_ACTIVE)
    && (vphase == tsg_pkg::TSG_ACTIVE);

  // sync and data outputs, one register each
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      hs_r <= 1'b0;
    end else if (step) begin
      hs_r <= (hphase == tsg_pkg::TSG_SYNC);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      vs_r <= 1'b0;
    end else if (step) begin
      vs_r <= (vphase == tsg_pkg::TSG_SYNC);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      de_r <= 1'b0;
    end else if (step) begin
      de_r <= act_area;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable_r) begin
      line_data <= '0;
    end else if (step) begin
      line_data <= act_area ? pix_r : 24'h000000;
    end
  end

  assign line_sync = hs_r ^ hpol_r;
  assign frame_sync = vs_r ^ vpol_r;
  assign pixel_valid_out = de_r;
endmodule // tsg_timing_gen

// file: verification/tsg_timing_gen_assertions.sv
`timescale 1ns/1ps
module tsg_timing_gen_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [tsg_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pixel_clk_out,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_out,
  input wire logic [23:0] line_data
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_clk_run;
    pixel_valid_out |-> $changed(pixel_clk_out);
  endproperty
  a_clk_run: assert property (p_clk_run)
    else $error("pixel clock stalled");
  property p_ls_hold;
    $changed(line_sync) |=> $stable(line_sync);
  endproperty
  a_ls_hold: assert property (p_ls_hold)
    else $error("line sync shorter than a pixel");
  property p_fs_span;
    aresetn && $changed(frame_sync) |-> $changed(line_sync);
  endproperty
  a_fs_span: assert property (p_fs_span)
    else $error("frame sync not aligned to line sync");
  property p_de_start;
    $rose(pixel_valid_out) |-> $stable(line_sync) && $stable(frame_sync);
  endproperty
  a_de_start: assert property (p_de_start)
    else $error("data enable rose inside sync");
  property p_data_off;
    !pixel_valid_out |-> line_data == 24'h000000;
  endproperty
  a_data_off: assert property (p_data_off)
    else $error("pixel data outside active area");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read response dropped");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy)
    else $error("read accepted while busy");
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response late");
endmodule // tsg_timing_gen_assertions

// file: verification/tsg_panel_model.sv
`timescale 1ns/1ps
module tsg_panel_model (
  input wire logic pixel_clk_out,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_out,
  input wire logic [23:0] line_data,
  input wire logic act_low,
  input wire logic clk_inv,
  output logic [15:0] line_len,
  output logic [15:0] frame_len,
  output logic [15:0] de_px,
  output logic [15:0] de_ln,
  output logic [23:0] px
);
  logic lq = 1'h0, fq = 1'h0;
  logic [15:0] pc = 16'h0, lc = 16'h0, dc = 16'h0, dl = 16'h0;
  logic pck;
  assign pck = pixel_clk_out ^ clk_inv;
  always @(posedge pck) begin
    lq <= line_sync ^ act_low;
    fq <= frame_sync ^ act_low;
    pc <= pc + 16'h1;
    if (pixel_valid_out) begin
      px <= line_data;
      dc <= dc + 16'h1;
    end
    if ((line_sync ^ act_low) && !lq) begin
      line_len <= pc;
      pc <= 16'h1;
      dc <= 16'h0;
      if (dc != 16'h0) de_px <= dc;
      lc <= lc + 16'h1;
      if ((frame_sync ^ act_low) && !fq) begin
        frame_len <= lc;
        lc <= 16'h1;
        de_ln <= dl;
        dl <= 16'h0;
      end else if (dc != 16'h0) dl <= dl + 16'h1;
    end
  end
endmodule // tsg_panel_model

// file: verification/tsg_timing_gen_tb.sv
`timescale 1ns/1ps
module tsg_timing_gen_tb;
  logic aclk = 1'h0, aresetn = 1'h0, act_low = 1'h0, clk_inv = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, pixel_clk_out, line_sync, frame_sync;
  logic pixel_valid_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] line_data, px;
  logic [15:0] line_len, frame_len, de_px, de_ln;
  int err_total = 0, n_compared = 0;
  always #4 aclk = ~aclk;
  tsg_timing_gen i_tsg_timing_gen (.*);
  tsg_panel_model i_tsg_panel_model (.*);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic tmo(input logic late);
    if (late) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    tmo(!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    check({30'h0, s_axi_bresp}, 32'h0);
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    tmo(!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    check(s_axi_rdata, e);
    check({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask
  task automatic run(input logic [1:0] pol, input logic inv,
                     input logic [3:0] w, input logic [3:0] h);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    act_low <= pol[0];
    clk_inv <= inv;
    wr(8'h10, {30'h0, pol});
    wr(8'h14, {24'h0, 2'h0, inv, 1'h0, 3'h0, inv});
    rd(8'h14, {24'h0, 2'h0, inv, 1'h0, 3'h0, inv}, 2'h0);
    @(posedge aclk);
    check({29'h0, pixel_clk_out, line_sync, frame_sync},
          {29'h0, inv, pol[0], pol[1]});
    wr(8'h04, {8'h00, 4'h0, h, 8'h00, 4'h0, w});
    wr(8'h08, 32'h00010302);
    wr(8'h0C, 32'h00010201);
    wr(8'h18, {8'h00, 24'hA5C33C ^ {24{inv}}});
    wr(8'h00, 32'h00000001);
    repeat (600) @(posedge aclk);
    check({16'h0, line_len}, {28'h0, w} + 32'h6);
    check({16'h0, frame_len}, {28'h0, h} + 32'h4);
    check({16'h0, de_px}, {28'h0, w});
    check({16'h0, de_ln}, {28'h0, h});
    check({8'h0, px}, {8'h00, 24'hA5C33C ^ {24{inv}}});
    $display("test pol %h inv %h done", pol, inv);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h04, 32'h01E00280, 2'h0);
    rd(8'h08, 32'h00103060, 2'h0);
    rd(8'h0C, 32'h000A2102, 2'h0);
    rd(8'h10, 32'h00000000, 2'h0);
    rd(8'h20, 32'h00000000, 2'h2);
    $display("test reset values done");
    run(2'h0, 1'h0, 4'h4, 4'h3);
    run(2'h3, 1'h1, 4'h5, 4'h2);
    finish_test();
  end
endmodule // tsg_timing_gen_tb
bind tsg_timing_gen tsg_timing_gen_assertions i_tsg_timing_gen_assertions (.*);
